// *** rtl/bpio_pkg.sv ***
// constants, field layouts and carrier types of the bit-mode parallel port block
package bpio_pkg;
	// all lines of the three ports in one vector: port one, port two, special port
	localparam int BPIO_LINES = 20;
	localparam int BPIO_ONE_LSB = 0;
	localparam int BPIO_TWO_LSB = 8;
	localparam int BPIO_SPEC_LSB = 16;
	localparam int BPIO_SPEC_WIDTH = 4;
	localparam logic [19:0] BPIO_ONE_LANES = 20'h0_00ff;
	localparam logic [19:0] BPIO_TWO_LANES = 20'h0_ff00;
	localparam logic [19:0] BPIO_SPEC_LANES = 20'hf_0000;
	// synchroniser vector: lines plus read strobe, write strobe and vector acknowledge
	localparam int BPIO_SYNC_WIDTH = 23;
	localparam logic [22:0] BPIO_SYNC_RESET = 23'h70_0000;
	localparam int BPIO_SYNC_RD = 20;
	localparam int BPIO_SYNC_WR = 21;
	localparam int BPIO_SYNC_ACK = 22;
	// register byte offsets; a port block is data, direction, polarity, special
	localparam logic [7:0] BPIO_FIELD_DATA = 8'h00;
	localparam logic [7:0] BPIO_FIELD_DIR = 8'h04;
	localparam logic [7:0] BPIO_FIELD_POL = 8'h08;
	localparam logic [7:0] BPIO_FIELD_SPEC = 8'h0c;
	localparam logic [7:0] BPIO_PORT_ONE_BASE = 8'h00;
	localparam logic [7:0] BPIO_PORT_TWO_BASE = 8'h10;
	localparam logic [7:0] BPIO_PORT_SPEC_BASE = 8'h20;
	localparam logic [7:0] BPIO_CS_ONE = 8'h30;
	localparam logic [7:0] BPIO_CS_TWO = 8'h34;
	localparam logic [7:0] BPIO_PAT_ONE = 8'h38;
	localparam logic [7:0] BPIO_PAT_TWO = 8'h3c;
	localparam logic [7:0] BPIO_CTRL = 8'h40;
	localparam logic [7:0] BPIO_VECTOR = 8'h44;
	localparam logic [7:0] BPIO_MATCH = 8'h48;
	// field positions
	localparam int BPIO_IE_BIT = 0;
	localparam int BPIO_IP_BIT = 1;
	localparam int BPIO_IUS_BIT = 2;
	localparam int BPIO_LINK_BIT = 0;
	localparam int BPIO_PAT_MASK_LSB = 8;
	localparam int BPIO_PROTECT_LSB = 4;
	// reset values
	localparam logic [19:0] BPIO_DIR_RESET = 20'hf_ffff;
	localparam logic [19:0] BPIO_LINES_RESET = 20'h0_0000;
	localparam logic [15:0] BPIO_PAT_RESET = 16'h0000;
	localparam logic [7:0] BPIO_VECTOR_RESET = 8'h00;
	// command and status bits of one 8-bit port
	typedef struct packed {
		logic under_service_flag;
		logic ip;
		logic ie;
	} bpio_cs_type;
	// drive of all port lines: level and output enable
	typedef struct packed {
		logic [19:0] level;
		logic [19:0] enable;
	} bpio_drive_type;
endpackage

// *** rtl/bpio_top.sv ***
// bit-mode parallel port block: two 8-bit ports, one 4-bit special port, apb registers
//
// Decided for this implementation: register access over APB and the placing of the registers.
module bpio_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port lines
	input wire logic [7:0] port_one_lines_in,
	output logic [7:0] port_one_lines_out,
	output logic [7:0] port_one_lines_oe,
	input wire logic [7:0] port_two_lines_in,
	output logic [7:0] port_two_lines_out,
	output logic [7:0] port_two_lines_oe,
	input wire logic [3:0] special_port_lines_in,
	output logic [3:0] special_port_lines_out,
	output logic [3:0] special_port_lines_oe,
	// strobes, acknowledge and priority chain
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic vector_ack_n,
	input wire logic chain_enable_in,
	output logic chain_enable_out,
	output logic interrupt_request_n,
	// timer access lines
	output logic [7:0] timer_lines_two,
	output logic [3:0] timer_lines_special
);
	import bpio_pkg::*;
	// synchroniser stages; stage one is read only by stage two
	logic [22:0] sync_one_reg, sync_two_reg, sync_three_reg, stable_reg, raw_inputs;
	// configuration and data, one bit per line
	logic [19:0] dir_reg, pol_reg, spec_reg, out_reg, catch_reg;
	// pattern, link, vector and interrupt state
	logic [15:0] pat_one_reg, pat_two_reg;
	logic link_reg;
	logic [7:0] vector_reg;
	bpio_cs_type cs_one_reg, cs_two_reg;
	logic match_one_reg, match_two_reg;
	// read data captured in the setup cycle
	logic [31:0] rdata_reg;
	logic err_reg;
	// derived controls, line vectors and decode
	logic dev_reset, match_one_now, match_two_now, ack_active, ack_one, ack_two;
	logic setup_cycle, write_done, read_done, addr_ok;
	logic [19:0] line_level, line_view, read_view, lanes, wide_wdata, protect, write_lanes;
	logic [7:0] port_base, field;
	logic [31:0] rdata_next;
	bpio_drive_type drive;
	// every pin input, strobe and acknowledge crosses into pclk
	assign raw_inputs = {vector_ack_n, write_strobe_n, read_strobe_n,
		special_port_lines_in, port_two_lines_in, port_one_lines_in};
	// four flops per input; a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < BPIO_SYNC_WIDTH; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_one_reg[gi] <= BPIO_SYNC_RESET[gi];
					sync_two_reg[gi] <= BPIO_SYNC_RESET[gi];
					sync_three_reg[gi] <= BPIO_SYNC_RESET[gi];
					stable_reg[gi] <= BPIO_SYNC_RESET[gi];
				end else begin
					sync_one_reg[gi] <= raw_inputs[gi];
					sync_two_reg[gi] <= sync_one_reg[gi];
					sync_three_reg[gi] <= sync_two_reg[gi];
					if (sync_two_reg[gi] == sync_three_reg[gi]) begin
						stable_reg[gi] <= sync_three_reg[gi];
					end
				end
			end
		end
	endgenerate
	// read and write strobes low together act as a full device reset
	assign dev_reset = !stable_reg[BPIO_SYNC_RD] && !stable_reg[BPIO_SYNC_WR];
	// pin levels and the polarity-corrected view of every line
	assign line_level = stable_reg[19:0];
	assign line_view = line_level ^ pol_reg;
	// read view: outputs show the driven value on the 8-bit ports, pins on the special port
	always_comb begin
		for (int i = 0; i < BPIO_LINES; i++) begin
			if (dir_reg[i] && spec_reg[i]) begin
				read_view[i] = catch_reg[i];
			end else if (dir_reg[i] || i >= BPIO_SPEC_LSB) begin
				read_view[i] = line_view[i];
			end else begin
				read_view[i] = out_reg[i];
			end
		end
	end
	// output drive: open-drain only pulls low, normal three-state drives both levels
	always_comb begin
		for (int i = 0; i < BPIO_LINES; i++) begin
			if (spec_reg[i]) begin
				drive.level[i] = 1'b0;
				drive.enable[i] = !dir_reg[i] && !(out_reg[i] ^ pol_reg[i]);
			end else begin
				drive.level[i] = out_reg[i] ^ pol_reg[i];
				drive.enable[i] = !dir_reg[i];
			end
		end
	end
	// split the line vector back onto the three port groups
	assign port_one_lines_out = drive.level[BPIO_ONE_LSB +: 8];
	assign port_one_lines_oe = drive.enable[BPIO_ONE_LSB +: 8];
	assign port_two_lines_out = drive.level[BPIO_TWO_LSB +: 8];
	assign port_two_lines_oe = drive.enable[BPIO_TWO_LSB +: 8];
	assign special_port_lines_out = drive.level[BPIO_SPEC_LSB +: BPIO_SPEC_WIDTH];
	assign special_port_lines_oe = drive.enable[BPIO_SPEC_LSB +: BPIO_SPEC_WIDTH];
	// timers see the synchronised, polarity-corrected lines of their ports
	assign timer_lines_two = line_view[BPIO_TWO_LSB +: 8];
	assign timer_lines_special = line_view[BPIO_SPEC_LSB +: BPIO_SPEC_WIDTH];
	// apb phases; the slave never waits, read data is ready from the setup cycle
	assign setup_cycle = psel && !penable;
	assign pready = psel && penable;
	assign write_done = pready && pwrite && !err_reg;
	assign read_done = pready && !pwrite && !err_reg;
	assign prdata = rdata_reg;
	assign pslverr = pready && err_reg;
	// address decode: port block base and field inside it
	assign port_base = {paddr[7:4], 4'h0};
	assign field = {4'h0, paddr[3:0]};
	always_comb begin
		unique case (port_base)
			BPIO_PORT_ONE_BASE: lanes = BPIO_ONE_LANES;
			BPIO_PORT_TWO_BASE: lanes = BPIO_TWO_LANES;
			BPIO_PORT_SPEC_BASE: lanes = BPIO_SPEC_LANES;
			default: lanes = BPIO_LINES_RESET;
		endcase
	end
	// write data placed on the addressed lanes; special port keeps its mask nibble apart
	always_comb begin
		unique case (port_base)
			BPIO_PORT_ONE_BASE: wide_wdata = {12'h000, pwdata[7:0]};
			BPIO_PORT_TWO_BASE: wide_wdata = {4'h0, pwdata[7:0], 8'h00};
			default: wide_wdata = {pwdata[3:0], 16'h0000};
		endcase
	end
	// a protect bit of 1 shields its special port data bit; settings fields take no mask
	assign protect = (port_base == BPIO_PORT_SPEC_BASE && field == BPIO_FIELD_DATA) ?
		{pwdata[BPIO_PROTECT_LSB +: BPIO_SPEC_WIDTH], 16'h0000} : BPIO_LINES_RESET;
	assign write_lanes = lanes & ~protect;
	// legal addresses; everything else answers with pslverr unless an acknowledge is active
	assign addr_ok = (paddr[1:0] == 2'h0) && ((lanes != BPIO_LINES_RESET) ||
		paddr == BPIO_CS_ONE || paddr == BPIO_CS_TWO || paddr == BPIO_PAT_ONE ||
		paddr == BPIO_PAT_TWO || paddr == BPIO_CTRL || paddr == BPIO_VECTOR ||
		paddr == BPIO_MATCH);
	// acknowledge: this device answers only if the chain grants it and it is pending
	assign ack_one = cs_one_reg.ip && cs_one_reg.ie && !cs_one_reg.under_service_flag;
	assign ack_two = cs_two_reg.ip && cs_two_reg.ie && !cs_two_reg.under_service_flag && !link_reg;
	assign ack_active = !stable_reg[BPIO_SYNC_ACK] && chain_enable_in && (ack_one || ack_two);
	// read mux, sampled in the setup cycle so the data is the state just before
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (ack_active) begin
			rdata_next = {24'h00_0000, vector_reg};
		end else if (lanes != BPIO_LINES_RESET) begin
			unique case (field)
				BPIO_FIELD_DATA: rdata_next = {12'h000, read_view & lanes};
				BPIO_FIELD_DIR: rdata_next = {12'h000, dir_reg & lanes};
				BPIO_FIELD_POL: rdata_next = {12'h000, pol_reg & lanes};
				default: rdata_next = {12'h000, spec_reg & lanes};
			endcase
			if (port_base == BPIO_PORT_TWO_BASE) begin
				rdata_next = rdata_next >> BPIO_TWO_LSB;
			end else if (port_base == BPIO_PORT_SPEC_BASE) begin
				rdata_next = rdata_next >> BPIO_SPEC_LSB;
			end
		end else begin
			unique case (paddr)
				BPIO_CS_ONE: rdata_next = {29'h0000_0000, cs_one_reg};
				BPIO_CS_TWO: rdata_next = {29'h0000_0000, cs_two_reg};
				BPIO_PAT_ONE: rdata_next = {16'h0000, pat_one_reg};
				BPIO_PAT_TWO: rdata_next = {16'h0000, pat_two_reg};
				BPIO_CTRL: rdata_next = {31'h0000_0000, link_reg};
				BPIO_VECTOR: rdata_next = {24'h00_0000, vector_reg};
				BPIO_MATCH: rdata_next = {30'h0000_0000, match_two_reg, match_one_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end
	// read data and error flag, both from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else if (setup_cycle) begin
			rdata_reg <= rdata_next;
			err_reg <= !addr_ok && !ack_active;
		end
	end

	// direction, polarity and special-function settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_reg <= BPIO_DIR_RESET;
			pol_reg <= BPIO_LINES_RESET;
			spec_reg <= BPIO_LINES_RESET;
		end else if (dev_reset) begin
			dir_reg <= BPIO_DIR_RESET;
			pol_reg <= BPIO_LINES_RESET;
			spec_reg <= BPIO_LINES_RESET;
		end else if (write_done && lanes != BPIO_LINES_RESET) begin
			if (field == BPIO_FIELD_DIR) begin
				dir_reg <= (dir_reg & ~write_lanes) | (wide_wdata & write_lanes);
			end
			if (field == BPIO_FIELD_POL) begin
				pol_reg <= (pol_reg & ~write_lanes) | (wide_wdata & write_lanes);
			end
			if (field == BPIO_FIELD_SPEC) begin
				spec_reg <= (spec_reg & ~write_lanes) | (wide_wdata & write_lanes);
			end
		end
	end

	// output data: only output bits take a write; writes to input bits change nothing here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg <= BPIO_LINES_RESET;
		end else if (dev_reset) begin
			out_reg <= BPIO_LINES_RESET;
		end else if (write_done && field == BPIO_FIELD_DATA) begin
			out_reg <= (out_reg & ~(write_lanes & ~dir_reg)) |
				(wide_wdata & write_lanes & ~dir_reg);
		end
	end

	// ones catchers: a high sets, a written 0 clears, and the set wins a tie
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			catch_reg <= BPIO_LINES_RESET;
		end else if (dev_reset) begin
			catch_reg <= BPIO_LINES_RESET;
		end else begin
			for (int i = 0; i < BPIO_LINES; i++) begin
				if (!(dir_reg[i] && spec_reg[i])) begin
					catch_reg[i] <= 1'b0; // a catcher that is not inserted holds nothing
				end else if (line_view[i]) begin
					catch_reg[i] <= 1'b1;
				end else if (write_done && field == BPIO_FIELD_DATA && write_lanes[i] && !wide_wdata[i]) begin
					catch_reg[i] <= 1'b0;
				end
			end
		end
	end

	// pattern match on the 8-bit ports only; the special port has none
	// linked ports match as one 16-bit word and port two's own matcher is idle
	assign match_one_now = ((((read_view[7:0] ^ pat_one_reg[7:0]) & pat_one_reg[15:8]) == 8'h00) &&
		(pat_one_reg[15:8] != 8'h00)) &&
		(!link_reg || (((read_view[15:8] ^ pat_two_reg[7:0]) & pat_two_reg[15:8]) == 8'h00));
	assign match_two_now = !link_reg && (pat_two_reg[15:8] != 8'h00) &&
		(((read_view[15:8] ^ pat_two_reg[7:0]) & pat_two_reg[15:8]) == 8'h00);

	// pattern, link and vector registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pat_one_reg <= BPIO_PAT_RESET;
			pat_two_reg <= BPIO_PAT_RESET;
			link_reg <= 1'b0;
			vector_reg <= BPIO_VECTOR_RESET;
		end else if (dev_reset) begin
			pat_one_reg <= BPIO_PAT_RESET;
			pat_two_reg <= BPIO_PAT_RESET;
			link_reg <= 1'b0;
			vector_reg <= BPIO_VECTOR_RESET;
		end else if (write_done) begin
			if (paddr == BPIO_PAT_ONE) begin
				pat_one_reg <= pwdata[15:0];
			end
			if (paddr == BPIO_PAT_TWO) begin
				pat_two_reg <= pwdata[15:0];
			end
			if (paddr == BPIO_CTRL) begin
				link_reg <= pwdata[BPIO_LINK_BIT];
			end
			if (paddr == BPIO_VECTOR) begin
				vector_reg <= pwdata[7:0];
			end
		end
	end

	// previous match state, so a pattern raises pending once on arrival
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_one_reg <= 1'b0;
			match_two_reg <= 1'b0;
		end else if (dev_reset) begin
			match_one_reg <= 1'b0;
			match_two_reg <= 1'b0;
		end else begin
			match_one_reg <= match_one_now;
			match_two_reg <= match_two_now;
		end
	end

	// command and status: enable writes, pending and service clear by writing 1; set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_one_reg <= '0;
			cs_two_reg <= '0;
		end else if (dev_reset) begin
			cs_one_reg <= '0;
			cs_two_reg <= '0;
		end else begin
			if (write_done && paddr == BPIO_CS_ONE) begin
				cs_one_reg.ie <= pwdata[BPIO_IE_BIT];
				cs_one_reg.ip <= cs_one_reg.ip && !pwdata[BPIO_IP_BIT]; // writing 1 clears
				cs_one_reg.under_service_flag <= cs_one_reg.under_service_flag && !pwdata[BPIO_IUS_BIT];
			end
			if (write_done && paddr == BPIO_CS_TWO) begin
				cs_two_reg.ie <= pwdata[BPIO_IE_BIT];
				cs_two_reg.ip <= cs_two_reg.ip && !pwdata[BPIO_IP_BIT]; // writing 1 clears
				cs_two_reg.under_service_flag <= cs_two_reg.under_service_flag && !pwdata[BPIO_IUS_BIT];
			end
			if (match_one_now && !match_one_reg) begin
				cs_one_reg.ip <= 1'b1;
			end
			if (match_two_now && !match_two_reg) begin
				cs_two_reg.ip <= 1'b1;
			end
			// the acknowledge read moves the highest pending port into service
			if (read_done && ack_active) begin
				if (ack_one) begin
					cs_one_reg.under_service_flag <= 1'b1;
				end else begin
					cs_two_reg.under_service_flag <= 1'b1;
				end
			end
		end
	end

	// request and priority chain; port one outranks port two
	assign interrupt_request_n = !(ack_one || ack_two);
	assign chain_enable_out = chain_enable_in && !cs_one_reg.under_service_flag && !cs_two_reg.under_service_flag &&
		!(!stable_reg[BPIO_SYNC_ACK] && (ack_one || ack_two));
endmodule

// *** sim/bpio_properties.sv ***
// concurrent checks on the bus and line pins of the port block
module bpio_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb side
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// line enables, raw pins and synchronised views
	input wire logic [7:0] port_one_lines_oe,
	input wire logic [7:0] port_two_lines_oe,
	input wire logic [3:0] special_port_lines_oe,
	input wire logic [7:0] port_two_lines_in,
	input wire logic [7:0] timer_lines_two,
	// strobes and priority chain
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic vector_ack_n,
	input wire logic chain_enable_in,
	input wire logic chain_enable_out
);
	// one domain, so clock and reset are stated once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero wait states: ready is the access phase itself
	a_ready_follows: assert property (pready == (psel && penable)) else $error("ready off access");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_err_mapped: assert property (psel && penable && paddr[1:0] == 2'b00 && paddr <= 8'h48 |-> !pslverr)
		else $error("error on mapped word");
	// acknowledge is synchronised, so it must have been idle for a while
	a_err_unmapped: assert property (vector_ack_n [*6] ##0 (psel && penable && paddr > 8'h48) |-> pslverr)
		else $error("no error on unmapped word");
	a_rdata_holds: assert property (psel && penable |=> $stable(prdata)) else $error("read data moved");
	a_chain_needs_in: assert property (chain_enable_out |-> chain_enable_in) else $error("chain out without in");
	a_strobe_reset: assert property ((!read_strobe_n && !write_strobe_n) [*8] |->
		port_one_lines_oe == 8'h00 && port_two_lines_oe == 8'h00 && special_port_lines_oe == 4'h0)
		else $error("strobe reset left outputs on");
	a_reset_inputs: assert property ($rose(presetn) |->
		port_one_lines_oe == 8'h00 && port_two_lines_oe == 8'h00 && special_port_lines_oe == 4'h0)
		else $error("lines not inputs after reset");
	// a fresh pin change cannot reach the timer view on the very next edge
	a_sync_delay: assert property ($stable(port_two_lines_in) [*6] ##1
		($changed(port_two_lines_in) && !(psel && penable && pwrite) && read_strobe_n) |=> $stable(timer_lines_two))
		else $error("pin bypassed synchroniser");
endmodule

// *** sim/bpio_pins_model.sv ***
// far-side devices on the port lines: pulled-up wires where any low driver wins
module bpio_pins_model
	import bpio_pkg::*;
(
	// drive from the block and from the far side
	input wire bpio_pkg::bpio_drive_type dev_drive,
	input wire bpio_pkg::bpio_drive_type ext_drive,
	// resolved wire levels
	output logic [19:0] level
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-up replaces any stale level once released; open-drain relies on it
	assign level = ~((dev_drive.enable & ~dev_drive.level) | (ext_drive.enable & ~ext_drive.level));
endmodule

// *** sim/tb.sv ***
// self-checking bench of the bit-mode port block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bpio_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, q;
	logic read_strobe_n, write_strobe_n, vector_ack_n, chain_enable_in;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, irq_n, ceo;
	wire logic [3:0] tls;
	wire logic [19:0] pins, dlev, doe;
	wire logic [7:0] tl2;
	wire bpio_drive_type dev_drive = {dlev, doe};
	bpio_drive_type ext_drive;
	// behavioural model of one port's settings
	int n_mismatch, n_tests, seed, m_dir, m_pol, m_dat, v, p;
	bpio_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_one_lines_in(pins[7:0]), .port_one_lines_out(dlev[7:0]), .port_one_lines_oe(doe[7:0]),
		.port_two_lines_in(pins[15:8]), .port_two_lines_out(dlev[15:8]), .port_two_lines_oe(doe[15:8]),
		.special_port_lines_in(pins[19:16]), .special_port_lines_out(dlev[19:16]),
		.special_port_lines_oe(doe[19:16]), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.vector_ack_n(vector_ack_n), .chain_enable_in(chain_enable_in), .chain_enable_out(ceo),
		.interrupt_request_n(irq_n), .timer_lines_two(tl2), .timer_lines_special(tls));
	bpio_pins_model u_pins (.dev_drive(dev_drive), .ext_drive(ext_drive), .level(pins));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one apb transfer; the request holds until ready is sampled
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait limit here: only the watchdog ends a hung transfer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check($sformatf("read %h", a), q, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog: the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		give_verdict;
	end
	initial begin
		seed = 14;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{read_strobe_n, write_strobe_n, vector_ack_n, chain_enable_in} = 4'hf;
		ext_drive = '0;
		idle(16);
		presetn <= 1'b1;
		// directions come up as inputs; an unmapped word is refused
		rd(8'h04, 32'h0000_00ff);
		rd(8'h14, 32'h0000_00ff);
		rd(8'h24, 32'h0000_000f);
		rd(8'h4c, 32'h0000_0000);
		check("slave error", e, 1'b1);
		// random direction, polarity, data and far-side levels on both 8-bit ports
		for (int i = 0; i < 8; i++) begin
			p = i % 2;
			m_dir = $random(seed) & 8'hff;
			m_pol = $random(seed) & 8'hff;
			m_dat = $random(seed) & 8'hff;
			v = $random(seed) & 8'hff;
			apb(1'b1, 8'(p * 16 + 12), 32'h0000_0000);
			apb(1'b1, 8'(p * 16 + 4), m_dir);
			apb(1'b1, 8'(p * 16 + 8), m_pol);
			apb(1'b1, 8'(p * 16), m_dat);
			ext_drive.level[p * 8 +: 8] <= v[7:0];
			ext_drive.enable[p * 8 +: 8] <= 8'hff;
			idle(8);
			check("enable", doe[p * 8 +: 8], ~m_dir & 8'hff);
			check("level", dlev[p * 8 +: 8] & ~m_dir, (m_dat ^ m_pol) & ~m_dir & 8'hff);
			rd(8'(p * 16), ((m_dat & ~m_dir) | ((v ^ m_pol) & m_dir)) & 8'hff);
			v = v & ~(~m_dir & ~(m_dat ^ m_pol));
			if (p == 1) check("timer view", tl2, (v ^ m_pol) & 8'hff);
		end
		// ones catcher on port one bit 0
		apb(1'b1, 8'h04, 32'h0000_00ff);
		apb(1'b1, 8'h08, 32'h0000_0000);
		apb(1'b1, 8'h0c, 32'h0000_0001);
		ext_drive.level[7:0] <= 8'h00;
		idle(8);
		apb(1'b1, 8'h00, 32'h0000_0000);
		ext_drive.level[0] <= 1'b1;
		idle(5);
		ext_drive.level[0] <= 1'b0;
		idle(8);
		rd(8'h00, 32'h0000_0001);
		apb(1'b1, 8'h00, 32'h0000_00ff);
		rd(8'h00, 32'h0000_0001);
		apb(1'b1, 8'h00, 32'h0000_0000);
		rd(8'h00, 32'h0000_0000);
		// open-drain outputs on port two, far side released
		ext_drive.enable[15:8] <= 8'h00;
		apb(1'b1, 8'h14, 32'h0000_0000);
		apb(1'b1, 8'h18, 32'h0000_0000);
		apb(1'b1, 8'h1c, 32'h0000_00ff);
		apb(1'b1, 8'h10, 32'h0000_000f);
		idle(2);
		check("open drain", doe[15:8], 8'hf0);
		rd(8'h10, 32'h0000_000f);
		// masked writes on the special port
		apb(1'b1, 8'h24, 32'h0000_0000);
		apb(1'b1, 8'h28, 32'h0000_0000);
		apb(1'b1, 8'h2c, 32'h0000_0000);
		apb(1'b1, 8'h20, 32'h0000_0000);
		m_dat = 0;
		for (int i = 0; i < 6; i++) begin
			v = $random(seed) & 8'hff;
			apb(1'b1, 8'h20, v);
			m_dat = ((m_dat & (v >> 4)) | (v & ~(v >> 4))) & 4'hf;
			idle(1);
			check("special level", dlev[19:16], m_dat);
		end
		// far side pulls bit 0 low; the read shows the pin, not the drive
		ext_drive.level[16] <= 1'b0;
		ext_drive.enable[16] <= 1'b1;
		idle(8);
		rd(8'h20, m_dat & 4'he);
		check("special timer view", tls, m_dat & 4'he);
		ext_drive.enable[16] <= 1'b0;
		// pattern match on port one, then the acknowledge cycle
		apb(1'b1, 8'h0c, 32'h0000_0000);
		apb(1'b1, 8'h44, 32'h0000_00a5);
		apb(1'b1, 8'h38, 32'h0000_ff3c);
		apb(1'b1, 8'h30, 32'h0000_0001);
		ext_drive.level[7:0] <= 8'h3c;
		idle(8);
		rd(8'h30, 32'h0000_0003);
		check("request", irq_n, 1'b0);
		vector_ack_n <= 1'b0;
		idle(6);
		rd(8'h00, 32'h0000_00a5);
		vector_ack_n <= 1'b1;
		idle(6);
		rd(8'h30, 32'h0000_0007);
		check("chain out in service", ceo, 1'b0);
		apb(1'b1, 8'h30, 32'h0000_0006);
		rd(8'h30, 32'h0000_0000);
		check("chain out idle", ceo, 1'b1);
		// linked ports: port one matches over both bytes, port two's own matcher idles
		apb(1'b1, 8'h40, 32'h0000_0001);
		apb(1'b1, 8'h3c, 32'h0000_ff00);
		rd(8'h48, 32'h0000_0000);
		apb(1'b1, 8'h3c, 32'h0000_ff0f);
		rd(8'h48, 32'h0000_0001);
		rd(8'h30, 32'h0000_0002);
		// one strobe alone changes nothing, both together reset
		apb(1'b1, 8'h04, 32'h0000_0000);
		chain_enable_in <= 1'b0;
		read_strobe_n <= 1'b0;
		idle(8);
		rd(8'h04, 32'h0000_0000);
		write_strobe_n <= 1'b0;
		idle(8);
		{read_strobe_n, write_strobe_n, chain_enable_in} <= 3'b111;
		idle(8);
		rd(8'h04, 32'h0000_00ff);
		rd(8'h44, 32'h0000_0000);
		give_verdict;
	end
endmodule
bind bpio_top bpio_properties u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port_one_lines_oe(port_one_lines_oe), .port_two_lines_oe(port_two_lines_oe),
	.special_port_lines_oe(special_port_lines_oe), .port_two_lines_in(port_two_lines_in),
	.timer_lines_two(timer_lines_two), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
	.vector_ack_n(vector_ack_n), .chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out));
